// ===== rtl/cms_pkg.sv
// Package: modes, diagnostic codes and timing constants of the CAN mode supervisor
package cms_pkg;
    typedef enum logic [2:0] {
        CHIP_INIT, CHIP_NORMAL, CHIP_STOP, CHIP_SLEEP, CHIP_RESTART, CHIP_FAILSAFE, CHIP_FLASH
    } cms_chip_mode_type;
    typedef enum logic [1:0] {
        XCVR_OFF, XCVR_WAKE, XCVR_NORMAL, XCVR_RXONLY
    } cms_xcvr_mode_type;
    // Diagnostic codes on the serial diagnostic field
    localparam logic [2:0] DIAG_NONE = 3'h0;
    localparam logic [2:0] DIAG_TXD_GND = 3'h1;
    localparam logic [2:0] DIAG_BUS_CLAMP = 3'h2;
    localparam logic [2:0] DIAG_TXRX_SHORT = 3'h3;
    localparam logic [2:0] DIAG_OVERTEMP = 3'h4;
    localparam logic [2:0] DIAG_RX_RECESSIVE = 3'h5;
    localparam logic [2:0] DIAG_BUS_LINE = 3'h6;
    // Clock and times
    localparam int CLK_MHZ = 250;
    localparam int DOM_TIMEOUT_MIN_NS = 300_000; // 0.3 ms
    localparam int DOM_TIMEOUT_MAX_NS = 1_000_000; // 1.0 ms
    localparam int DOM_TIMEOUT_TYP_NS = 600_000; // 0.6 ms
    localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_TYP_NS * CLK_MHZ / 1000;
    localparam int WAKE_FILTER_MIN_NS = 750; // 0.75 us
    localparam int WAKE_FILTER_MAX_NS = 5000; // 5 us
    localparam int WAKE_FILTER_CYC = (WAKE_FILTER_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RX_STUCK_EDGES = 8;
endpackage

// ===== rtl/cms_sync.sv
// Module: two-flip-flop synchroniser for a pin input
`timescale 1ns/100ps
module cms_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic pinIn,
    output logic syncOut
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // Next values; first stage feeds only the second
    always_comb begin
        meta_d = pinIn;
        sync_d = meta_q;
    end

    // Register both stages
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            meta_q <= RESET_VALUE;
            sync_q <= RESET_VALUE;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign syncOut = sync_q;
endmodule

// ===== rtl/cms_dom_timer.sv
// Module: dominant-level time-out counter with sticky expiry flag
`timescale 1ns/100ps
module cms_dom_timer #(
    parameter int LIMIT = 150000
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic dominant,
    input wire logic clearFlag,
    output logic expired
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic flag_q;
    logic flag_d;

    // Restart on every recessive level, saturate at the limit; set wins over clear
    always_comb begin
        count_d = count_q;
        if (!dominant) begin
            count_d = '0;
        end else if (count_q != LIMIT_C) begin
            count_d = count_q + CW'(1);
        end
        flag_d = flag_q;
        if (clearFlag) begin
            flag_d = 1'b0;
        end
        if (dominant && count_q == LIMIT_C) begin
            flag_d = 1'b1;
        end
    end

    // Register state
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
            flag_q <= 1'b0;
        end else begin
            count_q <= count_d;
            flag_q <= flag_d;
        end
    end

    assign expired = flag_q;
endmodule

// ===== rtl/cms_supervisor.sv
// Module: CAN transceiver mode and fault supervisor (top)
`timescale 1ns/100ps
// Summary of operation
// [RULE1] Only transceiver modes allowed in the present chip mode are accepted.
// [RULE2] Automatic transceiver mode changes stay inside the allowed set.
// [RULE3] Leaving normal for sleep or stop switches to the wake receiver; the code selects transceiver off instead unless the wake mode was already selected.
// [RULE4] Wake during a sleep command latches wake, abandons sleep, enters restart.
// [RULE5] Host should select wake-capable before ordering sleep or stop.
// [RULE6] Host must not change transceiver mode in the sleep command frame.
// [RULE7] In sleep with wake-capable, bus wake moves the chip to restart.
// [RULE8] All failures reported by code; TxD time-out reuses the TxD-to-ground code.
// [RULE9] Local failure or bus clamp forces receive-only mode.
// [RULE10] TxD dominant too long stops driving until commanded active again.
// [RULE11] Bus dominant too long flags clamp, receive-only, reports, interrupts.
// [RULE12] TxD-RxD short inhibits transmitter, reports, interrupts until command.
// [RULE13] Host should switch off transceiver supply after a TxD-RxD short.
// [RULE14] Overtemperature disables driver; resume after cooling and a TxD rising edge.
// [RULE15] RxD stuck recessive with bus traffic disables transmitter until command.
// [RULE16] Bus line shorts set the bus-failure flag and interrupt when unmasked.
// [RULE17] Bus line failures never change the transceiver mode.
// [RULE18] Host detects CANH-CANL short by TxD not echoed on RxD.
// [RULE19] Split output enabled in normal and receive-only, else high impedance.
// [RULE20] No own undervoltage detector; regulator status is passed to the host.
// [RULE21] Both dominant time-outs expire between 0.3 ms and 1.0 ms.
// [RULE22] Bus wake needs a dominant phase of at least the wake filter time.
// [RULE23] Receive-only keeps the driver off while RxD follows the bus.
// [RULE24] Transceiver off mode ignores every bus wake-up.
// [RULE25] Time-outs count clock cycles, restart when recessive, hold until cleared.
module cms_supervisor
    import cms_pkg::*;
#(
    parameter int DOM_CYCLES = cms_pkg::DOM_TIMEOUT_CYC,
    parameter int WAKE_CYCLES = cms_pkg::WAKE_FILTER_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    input wire cms_pkg::cms_chip_mode_type chipModeReq,
    input wire logic chipModeWr,
    input wire cms_pkg::cms_xcvr_mode_type xcvrModeReq,
    input wire logic xcvrModeWr,
    input wire logic sleepCmdBusy,
    input wire logic diagAck,
    input wire logic [2:0] intMask,
    input wire logic txdPin,
    input wire logic busRxDominant,
    input wire logic wakeRxDominant,
    input wire logic overTemp,
    input wire logic txRxShort,
    input wire logic busLineFault,
    input wire logic supplyUnderVolt,
    output cms_pkg::cms_chip_mode_type chipMode,
    output cms_pkg::cms_xcvr_mode_type xcvrMode,
    output logic driverEnable,
    output logic txdDominant,
    output logic rxdPin,
    output logic normalRxEnable,
    output logic wakeRxEnable,
    output logic splitEnable,
    output logic wakeFlag,
    output logic busFailFlag,
    output logic [2:0] diagCode,
    output logic intPin_n,
    output logic underVoltStatus
);
    import cms_pkg::*;

    logic txdS, busS, wakeS, otS, shortS, lineS, uvS;
    logic txdTimeout, busClamp;
    logic txdPrev_q, txdPrev_d;
    cms_chip_mode_type chip_q, chip_d;
    cms_xcvr_mode_type xcvr_q, xcvr_d;
    logic wake_q, wake_d, wakeArm_q, wakeArm_d;
    logic [15:0] wakeCnt_q, wakeCnt_d;
    logic txInhibit_q, txInhibit_d, otHold_q, otHold_d;
    logic short_q, short_d, rxStuck_q, rxStuck_d, busFail_q, busFail_d;
    logic [3:0] trafficCnt_q, trafficCnt_d;
    logic busPrev_q, busPrev_d, activeCmd;
    logic drv_q, txd_q, rxd_q, nrx_q, wrx_q, split_q, int_q, uv_q;
    logic [2:0] diag_q, diag_d;
    logic drv_d, rxd_d, int_d, wakeSeen;

    // Pin-level inputs pass two flip-flops before use; TxD idles recessive (high)
    cms_sync #(.RESET_VALUE(1'b1)) uSyncTxd (.mclk(mclk), .reset(reset), .pinIn(txdPin),
        .syncOut(txdS));
    cms_sync #(.RESET_VALUE(1'b0)) uSyncBus (.mclk(mclk), .reset(reset),
        .pinIn(busRxDominant), .syncOut(busS));
    cms_sync #(.RESET_VALUE(1'b0)) uSyncWake (.mclk(mclk), .reset(reset),
        .pinIn(wakeRxDominant), .syncOut(wakeS));
    cms_sync #(.RESET_VALUE(1'b0)) uSyncOt (.mclk(mclk), .reset(reset), .pinIn(overTemp),
        .syncOut(otS));
    cms_sync #(.RESET_VALUE(1'b0)) uSyncShort (.mclk(mclk), .reset(reset),
        .pinIn(txRxShort), .syncOut(shortS));
    cms_sync #(.RESET_VALUE(1'b0)) uSyncLine (.mclk(mclk), .reset(reset),
        .pinIn(busLineFault), .syncOut(lineS));
    cms_sync #(.RESET_VALUE(1'b0)) uSyncUv (.mclk(mclk), .reset(reset),
        .pinIn(supplyUnderVolt), .syncOut(uvS));

    // A host write of normal mode outside init is the command that releases the time-out, short and stuck-RxD latches
    assign activeCmd = xcvrModeWr && xcvrModeReq == XCVR_NORMAL && chip_q != CHIP_INIT;

    // Dominant time-outs in cycles; own TxD dominant is no bus clamp, so the TxD code wins
    cms_dom_timer #(.LIMIT(DOM_CYCLES)) uTxdTimer (.mclk(mclk), .reset(reset),
        .dominant(!txdS), .clearFlag(activeCmd), .expired(txdTimeout)); // [RULE10] [RULE21] [RULE25]
    cms_dom_timer #(.LIMIT(DOM_CYCLES)) uBusTimer (.mclk(mclk), .reset(reset),
        .dominant(busS && txdS), .clearFlag(activeCmd), .expired(busClamp)); // [RULE11] [RULE8]

    // Allowed transceiver modes per chip mode
    function automatic logic modeAllowed(input cms_chip_mode_type c, input cms_xcvr_mode_type x);
        logic ok;
        ok = 1'b0;
        unique case (c)
            CHIP_INIT: ok = (x == XCVR_OFF);
            CHIP_NORMAL: ok = 1'b1;
            CHIP_STOP, CHIP_SLEEP, CHIP_RESTART: ok = (x == XCVR_OFF || x == XCVR_WAKE);
            CHIP_FAILSAFE: ok = (x == XCVR_WAKE);
            CHIP_FLASH: ok = (x == XCVR_NORMAL);
            default: ok = 1'b0;
        endcase
        return ok; // [RULE1]
    endfunction

    // Nearest allowed mode after a chip mode change, keeping the present one where legal
    function automatic cms_xcvr_mode_type fitMode(input cms_chip_mode_type c,
            input cms_xcvr_mode_type x);
        cms_xcvr_mode_type r;
        r = x;
        if (!modeAllowed(c, x)) begin
            unique case (c)
                CHIP_FAILSAFE: r = XCVR_WAKE;
                CHIP_FLASH: r = XCVR_NORMAL;
                default: r = XCVR_OFF;
            endcase
        end
        return r; // [RULE2]
    endfunction

    // Wake filter: dominant on the wake receiver for the filter time, never in off mode
    always_comb begin
        wakeCnt_d = '0;
        if (wakeS && xcvr_q == XCVR_WAKE) begin // [RULE24]
            wakeCnt_d = (wakeCnt_q == 16'(WAKE_CYCLES)) ? wakeCnt_q : wakeCnt_q + 16'h0001;
        end
        wakeSeen = (wakeCnt_q == 16'(WAKE_CYCLES)) && wakeS && xcvr_q == XCVR_WAKE; // [RULE22]
        // Wake-capable must be left and re-entered before a new wake is taken
        wakeArm_d = wakeArm_q;
        if (wakeSeen) begin
            wakeArm_d = 1'b0;
        end else if (xcvr_q != XCVR_WAKE) begin
            wakeArm_d = 1'b1;
        end
        wake_d = wake_q;
        if (diagAck) begin
            wake_d = 1'b0;
        end
        if (wakeSeen && wakeArm_q) begin
            wake_d = 1'b1; // Set wins over clear
        end
    end

    // Chip and transceiver mode sequencing
    always_comb begin
        chip_d = chip_q;
        xcvr_d = xcvr_q;
        if (chipModeWr) begin
            chip_d = chipModeReq;
            // Wake during the sleep order bypasses sleep into restart
            if (chipModeReq == CHIP_SLEEP && (wake_q || (wakeSeen && wakeArm_q))) begin
                chip_d = CHIP_RESTART; // [RULE4]
            end
        end else if (chip_q == CHIP_SLEEP && wakeSeen && wakeArm_q) begin
            chip_d = CHIP_RESTART; // [RULE7]
        end
        if (sleepCmdBusy && wakeSeen && wakeArm_q && chip_q == CHIP_NORMAL) begin
            chip_d = CHIP_RESTART; // [RULE4]
        end
        if (xcvrModeWr && modeAllowed(chip_d, xcvrModeReq)) begin
            xcvr_d = xcvrModeReq; // [RULE1]
        end
        xcvr_d = fitMode(chip_d, xcvr_d); // [RULE2]
        // Local or clamp failure drops to receive-only where that mode exists
        if ((txdTimeout || busClamp || short_q) && xcvr_d == XCVR_NORMAL && !activeCmd
            && chip_d == CHIP_NORMAL) begin
            xcvr_d = XCVR_RXONLY; // [RULE9] [RULE2]
        end
        // Bus line faults deliberately leave the mode alone [RULE17]
    end

    // Fault latches
    always_comb begin
        txdPrev_d = txdS;
        busPrev_d = busS;
        short_d = short_q;
        if (activeCmd) begin
            short_d = 1'b0;
        end
        if (shortS) begin
            short_d = 1'b1; // [RULE12]
        end
        // Overtemperature holds the driver off until cool and a TxD rising edge
        otHold_d = otHold_q;
        if (otS) begin
            otHold_d = 1'b1;
        end else if (otHold_q && txdS && !txdPrev_q) begin
            otHold_d = 1'b0; // [RULE14]
        end
        // Bus edges seen while RxD stays recessive mean a stuck receive path
        trafficCnt_d = trafficCnt_q;
        if (rxd_q == 1'b0 || activeCmd) begin
            trafficCnt_d = '0;
        end else if (busS && !busPrev_q && trafficCnt_q != 4'(RX_STUCK_EDGES)) begin
            trafficCnt_d = trafficCnt_q + 4'h1;
        end
        rxStuck_d = rxStuck_q;
        if (activeCmd) begin
            rxStuck_d = 1'b0;
        end
        if (trafficCnt_q == 4'(RX_STUCK_EDGES)) begin
            rxStuck_d = 1'b1; // [RULE15]
        end
        busFail_d = busFail_q;
        if (diagAck) begin
            busFail_d = 1'b0;
        end
        if (lineS) begin
            busFail_d = 1'b1; // [RULE16]
        end
        txInhibit_d = txdTimeout || short_q || rxStuck_q || otHold_q; // [RULE10] [RULE15]
    end

    // Pin-facing outputs and reporting
    always_comb begin
        drv_d = (xcvr_q == XCVR_NORMAL) && !txInhibit_q && !busClamp; // [RULE23]
        rxd_d = 1'b1;
        if (xcvr_q == XCVR_NORMAL || xcvr_q == XCVR_RXONLY) begin
            rxd_d = !busS; // [RULE23]
        end else if (wake_q) begin
            rxd_d = 1'b0; // Woken node shows a low RxD
        end
        // Priority encoder of the diagnostic field
        if (short_q) begin
            diag_d = DIAG_TXRX_SHORT; // [RULE8]
        end else if (busClamp) begin
            diag_d = DIAG_BUS_CLAMP;
        end else if (txdTimeout) begin
            diag_d = DIAG_TXD_GND; // [RULE8]
        end else if (otHold_q) begin
            diag_d = DIAG_OVERTEMP;
        end else if (rxStuck_q) begin
            diag_d = DIAG_RX_RECESSIVE;
        end else if (busFail_q) begin
            diag_d = DIAG_BUS_LINE;
        end else begin
            diag_d = DIAG_NONE;
        end
        int_d = !((busClamp && !intMask[0]) || (short_q && !intMask[1])
            || (busFail_q && !intMask[2])); // [RULE11] [RULE12] [RULE16]
    end

    // Register every state group
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            chip_q <= CHIP_INIT;
            xcvr_q <= XCVR_OFF;
            wake_q <= 1'b0;
            wakeArm_q <= 1'b1;
            wakeCnt_q <= '0;
            txdPrev_q <= 1'b1;
            busPrev_q <= 1'b0;
            short_q <= 1'b0;
            otHold_q <= 1'b0;
            trafficCnt_q <= '0;
            rxStuck_q <= 1'b0;
            busFail_q <= 1'b0;
            txInhibit_q <= 1'b0;
            drv_q <= 1'b0;
            txd_q <= 1'b0;
            rxd_q <= 1'b1;
            nrx_q <= 1'b0;
            wrx_q <= 1'b0;
            split_q <= 1'b0;
            diag_q <= DIAG_NONE;
            int_q <= 1'b1;
            uv_q <= 1'b0;
        end else begin
            chip_q <= chip_d;
            xcvr_q <= xcvr_d;
            wake_q <= wake_d;
            wakeArm_q <= wakeArm_d;
            wakeCnt_q <= wakeCnt_d;
            txdPrev_q <= txdPrev_d;
            busPrev_q <= busPrev_d;
            short_q <= short_d;
            otHold_q <= otHold_d;
            trafficCnt_q <= trafficCnt_d;
            rxStuck_q <= rxStuck_d;
            busFail_q <= busFail_d;
            txInhibit_q <= txInhibit_d;
            drv_q <= drv_d;
            txd_q <= drv_d && !txdS;
            rxd_q <= rxd_d;
            nrx_q <= (xcvr_q == XCVR_NORMAL || xcvr_q == XCVR_RXONLY); // [RULE3]
            wrx_q <= (xcvr_q == XCVR_WAKE); // [RULE3]
            split_q <= (xcvr_q == XCVR_NORMAL || xcvr_q == XCVR_RXONLY); // [RULE19]
            diag_q <= diag_d;
            int_q <= int_d;
            uv_q <= uvS; // [RULE20]
        end
    end

    assign chipMode = chip_q;
    assign xcvrMode = xcvr_q;
    assign driverEnable = drv_q;
    assign txdDominant = txd_q;
    assign rxdPin = rxd_q;
    assign normalRxEnable = nrx_q;
    assign wakeRxEnable = wrx_q;
    assign splitEnable = split_q;
    assign wakeFlag = wake_q;
    assign busFailFlag = busFail_q;
    assign diagCode = diag_q;
    assign intPin_n = int_q;
    assign underVoltStatus = uv_q;
endmodule

// ===== verification/cms_supervisor_assertions.sv
// Checker: concurrent assertions on the ports of the CAN mode supervisor
`timescale 1ns/100ps
module cms_supervisor_assertions
    import cms_pkg::*;
#(
    parameter int DOM_CYCLES = 150000,
    parameter int WAKE_CYCLES = 188
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [2:0] intMask,
    input wire cms_pkg::cms_chip_mode_type chipMode,
    input wire cms_pkg::cms_xcvr_mode_type xcvrMode,
    input wire logic driverEnable,
    input wire logic txdDominant,
    input wire logic normalRxEnable,
    input wire logic splitEnable,
    input wire logic busFailFlag,
    input wire logic intPin_n
);
    // One clock domain; nothing is judged while reset holds
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // Mode pairs stay inside the permitted set, automatic moves included
    a_init_only_off:
        assert property (chipMode == CHIP_INIT |-> xcvrMode == XCVR_OFF)
        else $error("init with transceiver on");
    a_flash_only_normal:
        assert property (chipMode == CHIP_FLASH |-> xcvrMode == XCVR_NORMAL)
        else $error("flash without normal");
    a_failsafe_only_wake:
        assert property (chipMode == CHIP_FAILSAFE |-> xcvrMode == XCVR_WAKE)
        else $error("failsafe without wake");
    a_lowpower_no_active:
        assert property (chipMode inside {CHIP_STOP, CHIP_SLEEP, CHIP_RESTART}
            |-> xcvrMode inside {XCVR_OFF, XCVR_WAKE})
        else $error("active transceiver in low power");
    // Enables trail the mode by one cycle
    a_split_follows_mode:
        assert property (splitEnable == ($past(xcvrMode) inside {XCVR_NORMAL, XCVR_RXONLY}))
        else $error("split enable wrong");
    a_rxonly_no_drive:
        assert property (xcvrMode == XCVR_RXONLY |=> !driverEnable)
        else $error("driver on in receive only");
    // One cycle would do: the dominant output shares the enable's register stage
    a_drive_needs_enable:
        assert property (!driverEnable [*3] |-> !txdDominant)
        else $error("dominant without driver");
    a_sleep_rx_off:
        assert property (chipMode inside {CHIP_SLEEP, CHIP_STOP} |=> !normalRxEnable)
        else $error("normal receiver on in low power");
    a_busfail_irq:
        assert property ($rose(busFailFlag) && !intMask[2] |-> ##[0:2] !intPin_n)
        else $error("no interrupt on bus failure");
endmodule

// ===== verification/cms_host_model.sv
// Host controller model: stuffed random bits on TxD, own-bit echo check on RxD
`timescale 1ns/100ps
module cms_host_model #(
    parameter int BIT_CYC = 12
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    input wire logic txdHold,
    input wire logic rxdPin,
    output logic txdPin,
    output int missCount
);
    int same;
    logic nextBit;
    // Bit stuffing keeps healthy frames clear of the dominant time-out
    initial begin
        txdPin = 1'h1;
        forever begin
            @(posedge mclk);
            #1;
            if (!run || reset) begin
                txdPin = txdHold;
                same = 0;
            end else begin
                nextBit = (same >= 5) ? !txdPin : 1'($urandom % 2);
                same = (nextBit == txdPin) ? same + 1 : 1;
                txdPin = nextBit;
                repeat (BIT_CYC - 2) @(posedge mclk);
                #1;
                // A line short shows as an own bit missing on RxD
                if (rxdPin !== txdPin) begin
                    missCount++;
                end
            end
        end
    end
endmodule

// ===== verification/cms_supervisor_test.sv
// Bench: mode table, traffic echo, fault and wake scenarios of the supervisor
`timescale 1ns/100ps
module cms_supervisor_test;
    import cms_pkg::*;
    localparam int DOM = 80;
    localparam int WAKE = 4;
    localparam int BIT = 12;
    typedef struct {int sel; logic [2:0] val;} cms_note_type;
    logic mclk = 1'h0;
    logic reset = 1'h1;
    cms_chip_mode_type chipModeReq = CHIP_INIT;
    cms_xcvr_mode_type xcvrModeReq = XCVR_OFF;
    logic chipModeWr = 1'h0, xcvrModeWr = 1'h0, sleepCmdBusy = 1'h0, diagAck = 1'h0;
    logic [2:0] intMask = 3'h0;
    logic busRxDominant = 1'h0, wakeRxDominant = 1'h0, overTemp = 1'h0, txRxShort = 1'h0;
    logic busLineFault = 1'h0, supplyUnderVolt = 1'h0, run = 1'h0, txdHold = 1'h1;
    logic clampBus = 1'h0, txdPin, driverEnable, txdDominant, rxdPin, normalRxEnable;
    logic wakeRxEnable, splitEnable, wakeFlag, busFailFlag, intPin_n, underVoltStatus;
    logic [2:0] diagCode;
    cms_chip_mode_type chipMode;
    cms_xcvr_mode_type xcvrMode;
    int missCount, n_errors = 0, compares = 0;
    cms_note_type notes[$];
    event chk;

    cms_supervisor #(.DOM_CYCLES(DOM), .WAKE_CYCLES(WAKE)) uut (
        .mclk(mclk), .reset(reset), .chipModeReq(chipModeReq), .chipModeWr(chipModeWr),
        .xcvrModeReq(xcvrModeReq), .xcvrModeWr(xcvrModeWr), .sleepCmdBusy(sleepCmdBusy),
        .diagAck(diagAck), .intMask(intMask), .txdPin(txdPin), .busRxDominant(busRxDominant),
        .wakeRxDominant(wakeRxDominant), .overTemp(overTemp), .txRxShort(txRxShort),
        .busLineFault(busLineFault), .supplyUnderVolt(supplyUnderVolt), .chipMode(chipMode),
        .xcvrMode(xcvrMode), .driverEnable(driverEnable), .txdDominant(txdDominant),
        .rxdPin(rxdPin), .normalRxEnable(normalRxEnable), .wakeRxEnable(wakeRxEnable),
        .splitEnable(splitEnable), .wakeFlag(wakeFlag), .busFailFlag(busFailFlag),
        .diagCode(diagCode), .intPin_n(intPin_n), .underVoltStatus(underVoltStatus));
    cms_host_model #(.BIT_CYC(BIT)) host (.mclk(mclk), .reset(reset), .run(run),
        .txdHold(txdHold), .rxdPin(rxdPin), .txdPin(txdPin), .missCount(missCount));

    // Clock; bus dominant while driven or clamped
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) busRxDominant <= #1 txdDominant | clampBus;

    // Drivers change inputs 1 ns after an edge; xcvr drops its write strobe on the edge itself
    task automatic step(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic chip(cms_chip_mode_type m);
        chipModeReq = m;
        chipModeWr = 1'h1;
        step(1);
        chipModeWr = 1'h0;
    endtask
    task automatic xcvr(cms_xcvr_mode_type m);
        xcvrModeReq = m;
        xcvrModeWr = 1'h1;
        @(posedge mclk) xcvrModeWr <= 1'h0;
        #1;
    endtask
    task automatic pulse(int n);
        wakeRxDominant = 1'h1;
        step(n);
        wakeRxDominant = 1'h0;
        step(6);
    endtask
    task automatic ex(int s, logic [2:0] v);
        notes.push_back('{s, v});
        -> chk;
    endtask
    task automatic check(logic [2:0] seen, logic [2:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("[FAIL] %0t seen %0h want %0h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [2:0] obs(int s);
        case (s)
            0: return chipMode;
            1: return 3'(xcvrMode);
            2: return diagCode;
            3: return 3'(driverEnable);
            4: return 3'(splitEnable);
            5: return 3'(intPin_n);
            6: return 3'(busFailFlag);
            7: return 3'(wakeFlag);
            8: return 3'(rxdPin);
            9: return 3'(missCount != 0);
            10: return 3'(underVoltStatus);
            default: return {1'h0, wakeRxEnable, normalRxEnable};
        endcase
    endfunction
    // Requested mode if permitted, else the chip mode's fallback
    function automatic logic [2:0] want(int c, int x);
        logic ok;
        ok = c == 1 || (c == 0 && x == 0) || (c inside {[2:4]} && x < 2)
            || (c == 5 && x == 1) || (c == 6 && x == 2);
        return ok ? 3'(x) : (c == 5 ? 3'h1 : (c == 6 ? 3'h2 : 3'h0));
    endfunction

    // Watcher: compare each note with its output, oldest first
    initial forever begin
        @(chk);
        while (notes.size() > 0) begin
            check(obs(notes[0].sel), notes[0].val);
            notes.delete(0);
        end
    end

    // A hang counts as a mismatch
    initial begin
        #100us;
        n_errors++;
        summarize();
    end

    initial begin
        logic [2:0] w;
        void'($urandom(32'h5250_2421));
        step(2);
        reset = 1'h0;
        step(2);
        ex(0, CHIP_INIT);
        ex(1, XCVR_OFF);
        ex(8, 1'h1);
        ex(5, 1'h1);
        supplyUnderVolt = 1'h1;
        step(4);
        ex(10, 1'h1);
        supplyUnderVolt = 1'h0;
        $display("test reset done");
        for (int c = 0; c < 7; c++) begin
            for (int x = 0; x < 4; x++) begin
                chip(CHIP_INIT);
                step(1);
                chip(cms_chip_mode_type'(c));
                xcvr(cms_xcvr_mode_type'(x));
                step(1);
                w = want(c, x);
                ex(0, 3'(c));
                ex(1, w);
                ex(4, 3'(w >= 2));
            end
        end
        $display("test modes done");
        chip(CHIP_NORMAL);
        xcvr(XCVR_NORMAL);
        for (int k = 0; k < 2; k++) begin
            run = 1'h1;
            step(BIT * 24);
            run = 1'h0;
            step(BIT);
            ex(9, 3'(k));
            ex(3, 3'(k == 0));
            ex(4, 1'h1);
            xcvr(XCVR_RXONLY);
        end
        $display("test traffic done");
        xcvr(XCVR_NORMAL);
        intMask = {1'h0, 2'($urandom)};
        for (int k = 0; k < 2; k++) begin
            txdHold = (k == 1);
            clampBus = (k == 1);
            step(DOM - 1);
            ex(2, DIAG_NONE);
            step(12);
            ex(2, k ? DIAG_BUS_CLAMP : DIAG_TXD_GND);
            ex(1 + 2 * (1 - k), k ? 3'(XCVR_RXONLY) : 3'h0);
            ex(5, k ? intMask[0] : 1'h1);
            txdHold = 1'h1;
            clampBus = 1'h0;
            step(4);
            ex(2, k ? DIAG_BUS_CLAMP : DIAG_TXD_GND);
            xcvr(XCVR_NORMAL);
            step(3);
            ex(3, 1'h1);
            ex(2, DIAG_NONE);
        end
        $display("test timeouts done");
        txRxShort = 1'h1;
        step(6);
        ex(2, DIAG_TXRX_SHORT);
        ex(3, 1'h0);
        ex(5, intMask[1]);
        txRxShort = 1'h0;
        step(4);
        xcvr(XCVR_OFF);
        xcvr(XCVR_NORMAL);
        step(3);
        ex(3, 1'h1);
        busLineFault = 1'h1;
        step(6);
        ex(6, 1'h1);
        ex(5, 1'h0);
        ex(2, DIAG_BUS_LINE);
        ex(1, XCVR_NORMAL);
        ex(3, 1'h1);
        busLineFault = 1'h0;
        txdHold = 1'h0;
        overTemp = 1'h1;
        step(2);
        diagAck = 1'h1;
        step(1);
        diagAck = 1'h0;
        step(3);
        ex(6, 1'h0);
        ex(3, 1'h0);
        ex(2, DIAG_OVERTEMP);
        overTemp = 1'h0;
        step(5);
        ex(3, 1'h0);
        txdHold = 1'h1;
        step(6);
        ex(3, 1'h1);
        ex(1, XCVR_NORMAL);
        $display("test faults done");
        xcvr(XCVR_WAKE);
        step(1);
        chip(CHIP_SLEEP);
        pulse(WAKE - 2);
        ex(0, CHIP_SLEEP);
        ex(7, 1'h0);
        ex(11, 3'h2);
        pulse(WAKE + 6);
        ex(0, CHIP_RESTART);
        ex(7, 1'h1);
        ex(8, 1'h0);
        chip(CHIP_NORMAL);
        xcvr(XCVR_OFF);
        diagAck = 1'h1;
        step(1);
        diagAck = 1'h0;
        pulse(WAKE + 6);
        ex(7, 1'h0);
        xcvr(XCVR_WAKE);
        sleepCmdBusy = 1'h1;
        pulse(WAKE + 6);
        sleepCmdBusy = 1'h0;
        chip(CHIP_SLEEP);
        step(3);
        ex(0, CHIP_RESTART);
        ex(7, 1'h1);
        $display("test wake done");
        summarize();
    end
endmodule

bind cms_supervisor cms_supervisor_assertions #(.DOM_CYCLES(DOM_CYCLES),
    .WAKE_CYCLES(WAKE_CYCLES)) chkr (.mclk(mclk), .reset(reset), .intMask(intMask),
    .chipMode(chipMode), .xcvrMode(xcvrMode), .driverEnable(driverEnable),
    .txdDominant(txdDominant), .normalRxEnable(normalRxEnable), .splitEnable(splitEnable),
    .busFailFlag(busFailFlag), .intPin_n(intPin_n));
